// [bench/id_regs_checker.sv]
// assertions on the ports of the feature identification block
`timescale 1ns/1ps
`default_nettype none
module id_regs_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // read request and core state
   input wire logic        rd_valid,
   input wire logic [1:0]  rd_op0,
   input wire logic [2:0]  rd_op1,
   input wire logic [3:0]  rd_crn,
   input wire logic [3:0]  rd_crm,
   input wire logic [2:0]  rd_op2,
   input wire logic [1:0]  current_priv_level,
   input wire logic        el2_enabled,
   input wire logic        general_host_trap_bit,
   input wire logic        group3_id_trap_bit,
   // answer
   input wire logic        rsp_valid_q,
   input wire logic        rsp_hit_q,
   input wire logic [63:0] rsp_data_q,
   input wire logic        trap_q,
   input wire logic [1:0]  trap_level_q,
   input wire logic [5:0]  trap_class_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire [1:0] lv = current_priv_level;
   wire aux = rd_op0 == 2'h3 && rd_op1 == 3'h0 && rd_crn == 4'h0
              && rd_crm == 4'h5 && rd_op2[2:1] == 2'h2;
   resp_timing_a: assert property (rd_valid |=> rsp_valid_q)
      else $error("read not answered next cycle");
   resp_cause_a: assert property (rsp_valid_q |-> $past(rd_valid))
      else $error("answer without a read");
   el0_trap_a: assert property (rd_valid && lv == 2'h0 |=> !rsp_hit_q
      || trap_q && trap_level_q == ($past(el2_enabled
      && general_host_trap_bit) ? 2'h2 : 2'h1)) else $error("level 0 trap");
   el1_trap_a: assert property (rd_valid && lv == 2'h1 && el2_enabled
      && group3_id_trap_bit |=> !rsp_hit_q || trap_q && trap_level_q == 2'h2)
      else $error("level 1 trap missing");
   el1_pass_a: assert property (rd_valid && lv == 2'h1
      && !(el2_enabled && group3_id_trap_bit) |=> !trap_q)
      else $error("level 1 read trapped");
   high_lvl_a: assert property (rd_valid && lv[1] |=> !trap_q)
      else $error("level 2 or 3 read trapped");
   trap_data_a: assert property (trap_q |-> rsp_valid_q
      && rsp_data_q == 64'h0 && trap_class_q == 6'h18)
      else $error("bad trap answer");
   aux_zero_a: assert property (rd_valid && aux && lv[1]
      |=> rsp_hit_q && rsp_data_q == 64'h0) else $error("aux not zero");
   unmapped_a: assert property (rsp_valid_q && !rsp_hit_q
      |-> !trap_q && rsp_data_q == 64'h0) else $error("unmapped answer");
   no_trap_a: assert property (rsp_valid_q && !trap_q
      |-> trap_level_q == 2'h0 && trap_class_q == 6'h0)
      else $error("trap fields set without a trap");
endmodule
bind cpu_feature_id_regs id_regs_checker chk (
   .clk                   (clk),
   .rst_n                 (rst_n),
   .rd_valid              (rd_valid),
   .rd_op0                (rd_op0),
   .rd_op1                (rd_op1),
   .rd_crn                (rd_crn),
   .rd_crm                (rd_crm),
   .rd_op2                (rd_op2),
   .current_priv_level    (current_priv_level),
   .el2_enabled           (el2_enabled),
   .general_host_trap_bit (general_host_trap_bit),
   .group3_id_trap_bit    (group3_id_trap_bit),
   .rsp_valid_q           (rsp_valid_q),
   .rsp_hit_q             (rsp_hit_q),
   .rsp_data_q            (rsp_data_q),
   .trap_q                (trap_q),
   .trap_level_q          (trap_level_q),
   .trap_class_q          (trap_class_q)
);
`default_nettype wire

// [bench/tb_cpu_feature_id_regs.sv]
// self-checking bench for the feature identification registers
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_feature_id_regs;
   logic clk = 0, rst_n = 0, rd_valid = 0, el2_enabled = 0;
   logic general_host_trap_bit = 0, group3_id_trap_bit = 0;
   logic cipher_enable = 1, rsp_valid_q, rsp_hit_q, trap_q;
   logic [1:0] rd_op0 = 2'h3, current_priv_level = 2'h0, trap_level_q;
   logic [2:0] rd_op1 = 3'h0, rd_op2 = 3'h0;
   logic [3:0] rd_crn = 4'h0, rd_crm = 4'h0;
   logic [5:0] trap_class_q;
   logic [63:0] rsp_data_q, min_data;
   int bad_count = 0, samples_checked = 0;
   cpu_feature_id_regs dut (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .rd_valid              (rd_valid),
      .rd_op0                (rd_op0),
      .rd_op1                (rd_op1),
      .rd_crn                (rd_crn),
      .rd_crm                (rd_crm),
      .rd_op2                (rd_op2),
      .current_priv_level    (current_priv_level),
      .el2_enabled           (el2_enabled),
      .general_host_trap_bit (general_host_trap_bit),
      .group3_id_trap_bit    (group3_id_trap_bit),
      .cipher_enable         (cipher_enable),
      .rsp_valid_q           (rsp_valid_q),
      .rsp_hit_q             (rsp_hit_q),
      .rsp_data_q            (rsp_data_q),
      .trap_q                (trap_q),
      .trap_level_q          (trap_level_q),
      .trap_class_q          (trap_class_q)
   );
   // build with neither option, to see both option fields read zero
   cpu_feature_id_regs #(.HAS_RANDOM_NUMBER_FIELD(0), .HAS_CRYPTO(0)) dut_min (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .rd_valid              (rd_valid),
      .rd_op0                (rd_op0),
      .rd_op1                (rd_op1),
      .rd_crn                (rd_crn),
      .rd_crm                (rd_crm),
      .rd_op2                (rd_op2),
      .current_priv_level    (current_priv_level),
      .el2_enabled           (el2_enabled),
      .general_host_trap_bit (general_host_trap_bit),
      .group3_id_trap_bit    (group3_id_trap_bit),
      .cipher_enable         (cipher_enable),
      .rsp_valid_q           (),
      .rsp_hit_q             (),
      .rsp_data_q            (min_data),
      .trap_q                (),
      .trap_level_q          (),
      .trap_class_q          ()
   );
   always #20 clk = ~clk;
   task cmp(string n, logic [63:0] e, g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // rd_valid stays high so that reads run back to back
   task rd(logic [1:0] l, logic [3:0] m, logic [2:0] o,
           logic t, logic [1:0] tl, logic [63:0] d);
      logic h;
      current_priv_level = l;
      rd_crm = m;
      rd_op2 = o;
      rd_valid = 1;
      @(posedge clk);
      h = rd_op0 == 2'h3 && rd_op1 == 3'h0 && rd_crn == 4'h0 &&
          {m, o} inside {7'h2c, 7'h2d, 7'h30};
      t = t && h;
      #1 cmp("valid", 1, rsp_valid_q);
      cmp("hit", h, rsp_hit_q);
      cmp("trap", t, trap_q);
      cmp("level", t ? tl : 2'h0, trap_level_q);
      cmp("class", t ? 6'h18 : 6'h0, trap_class_q);
      cmp("data", (t || !h) ? 64'h0 : d, rsp_data_q);
   endtask
   // every output reads zero under reset and with no read taken
   task idle_chk();
      cmp("valid idle", 0, rsp_valid_q);
      cmp("hit idle", 0, rsp_hit_q);
      cmp("data idle", 0, rsp_data_q);
      cmp("trap idle", 0, trap_q);
      cmp("level idle", 0, trap_level_q);
      cmp("class idle", 0, trap_class_q);
   endtask
   task end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #20000 bad_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 idle_chk();
      rst_n = 1;
      rd(2'h2, 4'h5, 3'h4, 0, 0, 64'h0);
      rd(2'h3, 4'h5, 3'h5, 0, 0, 64'h0);
      rd(2'h1, 4'h7, 3'h4, 0, 0, 64'h0);
      rd_crn = 4'h1;
      rd(2'h2, 4'h5, 3'h4, 0, 0, 64'h0);
      rd_crn = 4'h0;
      $display("test aux done");
      rd(2'h1, 4'h6, 3'h0, 0, 0, 64'h1221_1100_0000_0000);
      cmp("data no options", 64'h0221_1000_0000_0000, min_data);
      cipher_enable = 0;
      rd(2'h2, 4'h6, 3'h0, 0, 0, 64'h1221_1000_0000_0000);
      $display("test isa done");
      for (int i = 0; i < 4; i++) begin
         {el2_enabled, general_host_trap_bit} = i[1:0];
         group3_id_trap_bit = i[0];
         rd(2'h0, 4'h5, 3'h5, 1, (i == 3) ? 2'h2 : 2'h1, 0);
         rd(2'h1, 4'h5, 3'h4, i == 3, 2'h2, 64'h0);
         rd(2'h3, 4'h6, 3'h0, 0, 0, 64'h1221_1000_0000_0000);
      end
      $display("test trap done");
      rst_n = 0;
      @(posedge clk);
      #1 idle_chk();
      rst_n = 1;
      rd_valid = 0;
      @(posedge clk);
      #1 idle_chk();
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire

// [hdl/cpu_feature_id_regs.v]
// feature identification registers with privilege-gated read path
// Notes on behaviour
// - the first auxiliary feature register is 64 reserved bits reading zero.
// - the second auxiliary register is 64 bits, resets to and reads zero.
// - the first auxiliary register is op0 3, op1 0, CRm 5, op2 4.
// - the second auxiliary register is op0 3, op1 0, CRn 0, CRm 5, op2 5.
// - level 0 reads trap, class 0x18, to level 2 if el2 and host bit, else 1.
// - level 1 reads trap to level 2, class 0x18, if el2 and group-3 bit set.
// - reads at level 2 or 3 return the contents with no trap check.
// - the random number field reads 1 when that option is built in, else 0.
// - the translation maintenance field reads 2.
// - the flag manipulation field reads 2.
// - the half-precision multiply-accumulate field reads 1.
// - the dot product field at bits 47:44 reads 1.
// - cipher field reads 1 only with crypto built in and enabled, else 0.
`timescale 1ns/1ps
`default_nettype none
`include "feature_id_defs.vh"

module cpu_feature_id_regs #(
   parameter HAS_RANDOM_NUMBER_FIELD   = 1,
   parameter HAS_CRYPTO = 1
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // read request
   input  wire        rd_valid,
   input  wire [1:0]  rd_op0,
   input  wire [2:0]  rd_op1,
   input  wire [3:0]  rd_crn,
   input  wire [3:0]  rd_crm,
   input  wire [2:0]  rd_op2,
   // core state, same clock domain
   input  wire [1:0]  current_priv_level,
   input  wire        el2_enabled,
   input  wire        general_host_trap_bit,
   input  wire        group3_id_trap_bit,
   input  wire        cipher_enable,
   // answer
   output reg         rsp_valid_q,
   output reg         rsp_hit_q,
   output reg  [63:0] rsp_data_q,
   output reg         trap_q,
   output reg  [1:0]  trap_level_q,
   output reg  [5:0]  trap_class_q
);

   // ----------------------------------------------------------------
   // register contents
   // ----------------------------------------------------------------
   // held as constants: nothing writes them, so no storage is spent
   wire [63:0] aux_feature_id_0 = `AUX_ID_RESET;
   wire [63:0] aux_feature_id_1 = `AUX_ID_RESET;
   wire [3:0]  random_number_field =
      (HAS_RANDOM_NUMBER_FIELD != 0) ? `VAL_RANDOM_NUMBER_FIELD_ON : `VAL_ZERO4;
   wire [3:0]  block_cipher_field =
      ((HAS_CRYPTO != 0) && cipher_enable) ? `VAL_CIPH_ON
                                           : `VAL_ZERO4;
   // build options are parameters; cipher_enable alone can move at run time
   wire [63:0] isa_attribute_id_0;

   // the six listed attribute fields, the cipher field last
   localparam NUM_FIELDS = 6;
   wire [NUM_FIELDS*`FIELD_W-1:0] field_vals = {
      random_number_field,
      `VAL_TLBM,
      `VAL_FLAG,
      `VAL_HFMA,
      `VAL_DOTP,
      block_cipher_field
   };

   // bit position of field idx, counted upward from the cipher field
   function integer field_lsb;
      input integer idx;
      begin
         case (idx)
            0:       field_lsb = `CIPH_LSB;
            1:       field_lsb = `DOTP_LSB;
            2:       field_lsb = `HFMA_LSB;
            3:       field_lsb = `FLAG_LSB;
            4:       field_lsb = `TLBM_LSB;
            5:       field_lsb = `RANDOM_NUMBER_FIELD_LSB;
            default: field_lsb = `CIPH_LSB;
         endcase
      end
   endfunction

   genvar f;
   generate
      for (f = 0; f < NUM_FIELDS; f = f + 1) begin : g_field
         assign isa_attribute_id_0[field_lsb(f) +: `FIELD_W] =
            field_vals[f*`FIELD_W +: `FIELD_W];
      end
   endgenerate

   // fields below the listed ones are left out and read zero
   assign isa_attribute_id_0[`CIPH_LSB-1:0] = {`CIPH_LSB{1'h0}};

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire base_hit = (rd_op0 == `ENC_OP0) && (rd_op1 == `ENC_OP1) &&
                   (rd_crn == `ENC_CRN);
   wire sel_aux0 = base_hit && (rd_crm == `ENC_CRM) &&
                   (rd_op2 == `ENC_OP2_AUX0);
   wire sel_aux1 = base_hit && (rd_crm == `ENC_CRM) &&
                   (rd_op2 == `ENC_OP2_AUX1);
   wire sel_isa0 = base_hit && (rd_crm == `ENC_CRM_ISA0) &&
                   (rd_op2 == `ENC_OP2_ISA0);
   wire hit      = sel_aux0 | sel_aux1 | sel_isa0;
   wire [2:0] sel_onehot = {sel_aux0, sel_aux1, sel_isa0};

   // ----------------------------------------------------------------
   // register select
   // ----------------------------------------------------------------
   // one-hot select codes, at most one encoding matches
   localparam SEL_AUX0 = 3'h4;
   localparam SEL_AUX1 = 3'h2;
   localparam SEL_ISA0 = 3'h1;

   reg [63:0] sel_data;
   always @* begin
      sel_data = `ZERO_DATA;
      case (sel_onehot)
         SEL_AUX0: sel_data = aux_feature_id_0;
         SEL_AUX1: sel_data = aux_feature_id_1;
         SEL_ISA0: sel_data = isa_attribute_id_0;
         default:  sel_data = `ZERO_DATA;
      endcase
   end

   // ----------------------------------------------------------------
   // privilege gating
   // ----------------------------------------------------------------
   // level 0 reads of mapped registers always trap, so no contents ever reach level 0
   wire host_route = el2_enabled && general_host_trap_bit;
   wire guest_trap = el2_enabled && group3_id_trap_bit;

   reg       trap_req;
   reg [1:0] trap_lvl;
   always @* begin
      trap_req = 1'h0;
      trap_lvl = `PRIV_L1;
      case (current_priv_level)
         `PRIV_L0: begin
            trap_req = 1'h1;
            trap_lvl = host_route ? `PRIV_L2 : `PRIV_L1;
         end
         `PRIV_L1: begin
            trap_req = guest_trap;
            trap_lvl = `PRIV_L2;
         end
         default: begin
            trap_req = 1'h0;
            trap_lvl = `PRIV_L1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next answer
   // ----------------------------------------------------------------
   // unmapped encodings answer with hit low and zero data, never trap
   wire take = rd_valid && hit;

   reg         rsp_valid_d;
   reg         rsp_hit_d;
   reg  [63:0] rsp_data_d;
   reg         trap_d;
   reg  [1:0]  trap_level_d;
   reg  [5:0]  trap_class_d;

   always @* begin
      rsp_valid_d  = rd_valid;
      rsp_hit_d    = take;
      rsp_data_d   = `ZERO_DATA;
      trap_d       = 1'h0;
      trap_level_d = `NO_TRAP_LVL;
      trap_class_d = `NO_TRAP_CLASS;
      if (take && trap_req) begin
         trap_d       = 1'h1;
         trap_level_d = trap_lvl;
         trap_class_d = `TRAP_CLASS_SYS;
      end else if (take) begin
         rsp_data_d   = sel_data;
      end
   end

   // ----------------------------------------------------------------
   // answer registers
   // ----------------------------------------------------------------
   // the answer lands one cycle after the request; trap and data exclusive
   always @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid_q  <= 1'h0;
         rsp_hit_q    <= 1'h0;
         rsp_data_q   <= `ZERO_DATA;
      end else begin
         rsp_valid_q  <= rsp_valid_d;
         rsp_hit_q    <= rsp_hit_d;
         rsp_data_q   <= rsp_data_d;
      end
   end

   // trap level and class read zero whenever no trap is taken
   always @(posedge clk) begin
      if (!rst_n) begin
         trap_q       <= 1'h0;
         trap_level_q <= `NO_TRAP_LVL;
         trap_class_q <= `NO_TRAP_CLASS;
      end else begin
         trap_q       <= trap_d;
         trap_level_q <= trap_level_d;
         trap_class_q <= trap_class_d;
      end
   end

endmodule

`default_nettype wire

// [shared/feature_id_defs.vh]
// constants for the feature identification register block
`ifndef FEATURE_ID_DEFS_VH
`define FEATURE_ID_DEFS_VH

// ----------------------------------------------------------------
// read encoding
// ----------------------------------------------------------------
`define ENC_OP0          2'h3
`define ENC_OP1          3'h0
`define ENC_CRN          4'h0
`define ENC_CRM          4'h5
`define ENC_OP2_AUX0     3'h4
`define ENC_OP2_AUX1     3'h5
`define ENC_OP2_ISA0     3'h0
`define ENC_CRM_ISA0     4'h6

// ----------------------------------------------------------------
// privilege levels and trap class
// ----------------------------------------------------------------
`define PRIV_L0          2'h0
`define PRIV_L1          2'h1
`define PRIV_L2          2'h2
`define TRAP_CLASS_SYS   6'h18

// ----------------------------------------------------------------
// register values and field positions
// ----------------------------------------------------------------
`define AUX_ID_RESET     64'h0
`define RANDOM_NUMBER_FIELD_LSB         60
`define TLBM_LSB         56
`define FLAG_LSB         52
`define HFMA_LSB         48
`define DOTP_LSB         44
`define CIPH_LSB         40
`define VAL_RANDOM_NUMBER_FIELD_ON      4'h1
`define VAL_TLBM         4'h2
`define VAL_FLAG         4'h2
`define VAL_HFMA         4'h1
`define VAL_DOTP         4'h1
`define VAL_CIPH_ON      4'h1
`define VAL_ZERO4        4'h0
`define FIELD_W          4
`define ZERO_DATA        64'h0
`define NO_TRAP_LVL      2'h0
`define NO_TRAP_CLASS    6'h0

`endif
